// ===== core/adport_defines.svh
`ifndef ADPORT_DEFINES_SVH
`define ADPORT_DEFINES_SVH

// Register indices; each register's byte address is four times its index
`define UP_DIR_IDX    16'hffb1
`define UP_DATA_IDX   16'hffb3
`define DB_DIR_IDX    16'hffb4
`define DB_DATA_IDX   16'hffb6
`define HS_CTRL_IDX   16'hffbf

// Byte addresses on the APB
`define UP_DIR_ADDR   {14'h0000, `UP_DIR_IDX, 2'b00}
`define UP_DATA_ADDR  {14'h0000, `UP_DATA_IDX, 2'b00}
`define DB_DIR_ADDR   {14'h0000, `DB_DIR_IDX, 2'b00}
`define DB_DATA_ADDR  {14'h0000, `DB_DATA_IDX, 2'b00}
`define HS_CTRL_ADDR  {14'h0000, `HS_CTRL_IDX, 2'b00}

// Reset values, direction read-back value and mode 1 direction value
`define UP_DIR_RST    8'h00
`define UP_DATA_RST   8'h00
`define DB_DIR_RST    8'h00
`define DB_DATA_RST   8'h00
`define DIR_READ_VAL  8'hff
`define MODE1_DIR_VAL 8'hff

// Field positions
`define LATCH_EN_BIT  0

`endif

// ===== core/adport_pkg.sv
package adport_pkg;

  // Operating mode, fixed by the mode pins
  typedef enum logic [1:0] {
    MODE_RSV,
    MODE_EXP_NOROM,
    MODE_EXP_ROM,
    MODE_SINGLE
  } mode_t;

  // Drive of one 8-bit pin group
  typedef struct packed {
    logic [7:0] o;
    logic [7:0] oe;
    logic [7:0] pu;
  } pin_drive_t;

  // Request from the handshake control logic
  typedef struct packed {
    logic       active;
    logic       oe;
    logic [7:0] data;
  } hs_req_t;

endpackage

// ===== core/address_data_port_pair.sv
`timescale 1ns/1ps
`default_nettype none
`include "adport_defines.svh"

// Summary of operation
// RQ1: Mode 1 drives upper address on all pins
// RQ2: Mode 1 direction ignores writes, stays ones
// RQ3: Mode 2 per-pin input or address output
// RQ4: Mode 3 upper port is plain I/O
// RQ5: Modes 2,3 data bit sets input pull-up
// RQ6: Pull-ups off for outputs and mode 1
// RQ7: Reset clears; mode 1 then sets direction
// RQ8: Hardware standby floats pins, pull-ups off
// RQ9: Software standby: address low, rest kept
// RQ10: Modes 1,2 data port is data bus
// RQ11: Mode 3 data port GPIO or handshake
// RQ12: Mode 3 data port direction per bit
// RQ13: Mode 3 only data-port input pull-ups
// RQ14: Strobe falling edge latches data port pins
// RQ15: Latch disabled reads live pin levels
// RQ16: Reset, hardware standby clear data port
// RQ17: Software standby keeps data port state
// RQ18: Data read: latch for outputs, pin inputs
// RQ19: Direction registers read as all ones
// RQ20: Mode static; muxing derived combinationally
module address_data_port_pair
  import adport_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire mode_t       op_mode,
  input  wire logic        hw_standby,
  input  wire logic        sw_standby,
  input  wire logic [7:0]  upper_address_byte,
  input  wire logic [7:0]  ext_data_out,
  input  wire logic        ext_data_oe,
  output logic      [7:0]  ext_data_in,
  input  wire hs_req_t     hs_req,
  input  wire logic        input_strobe_n,
  input  wire logic [7:0]  up_pin_i,
  output pin_drive_t       up_pin,
  input  wire logic [7:0]  db_pin_i,
  output pin_drive_t       db_pin,
  output logic             strobe_latch_enable
);

  // Register state
  logic [7:0] up_dir_q;          // Upper port direction
  logic [7:0] up_data_q;         // Upper port data latch
  logic [7:0] db_dir_q;          // Data port direction
  logic [7:0] db_data_q;         // Data port data latch
  logic       latch_en_q;        // Strobe latch enable
  logic [7:0] strobe_latch_q;    // Held strobed input
  logic       strobe_prev_q;     // Previous strobe level
  logic       pready_q;          // APB answer
  logic       pslverr_q;         // Unmapped address answer
  logic [31:0] prdata_q;         // Read data
  pin_drive_t up_pin_q;          // Registered upper pin drive
  pin_drive_t db_pin_q;          // Registered data pin drive
  logic [7:0] ext_data_in_q;     // Data bus toward the core

  // Mode decode, static during operation
  wire logic m1 = (op_mode == MODE_EXP_NOROM);            // RQ20
  wire logic m2 = (op_mode == MODE_EXP_ROM);              // RQ20
  wire logic m3 = !m1 && !m2;                             // RQ20
  wire logic expanded = m1 || m2;

  // APB decode
  wire logic setup_ph = psel && !penable;
  wire logic wr_en    = psel && penable && pready_q && pwrite;
  wire logic hit_up_dir  = (paddr == `UP_DIR_ADDR);
  wire logic hit_up_data = (paddr == `UP_DATA_ADDR);
  wire logic hit_db_dir  = (paddr == `DB_DIR_ADDR);
  wire logic hit_db_data = (paddr == `DB_DATA_ADDR);
  wire logic hit_hs      = (paddr == `HS_CTRL_ADDR);
  wire logic hit_any = hit_up_dir || hit_up_data || hit_db_dir || hit_db_data || hit_hs;

  // Strobe falling edge, qualified by mode 3 and latch enable
  wire logic strobe_fall = strobe_prev_q && !input_strobe_n;
  wire logic capture     = m3 && latch_en_q && strobe_fall; // RQ14

  // Data port input source: held value or transparent path
  wire logic [7:0] db_in_src = (m3 && latch_en_q) ? strobe_latch_q : db_pin_i; // RQ14 RQ15

  // Read values: latch for output pins, pin level for inputs
  wire logic [7:0] up_rd = (up_dir_q & up_data_q) | (~up_dir_q & up_pin_i);  // RQ18
  wire logic [7:0] db_rd = (db_dir_q & db_data_q) | (~db_dir_q & db_in_src); // RQ18

  // Read mux; direction registers are write-only
  wire logic [7:0] rd_byte =
    (hit_up_dir || hit_db_dir) ? `DIR_READ_VAL :                             // RQ19
    hit_up_data ? up_rd :
    hit_db_data ? db_rd :
    hit_hs      ? {7'h00, latch_en_q} : 8'h00;

  // Upper port: pins carrying address in the expanded modes
  wire logic [7:0] up_addr_sel = expanded ? up_dir_q : 8'h00;               // RQ1 RQ3
  // Address outputs go low in software standby
  wire logic [7:0] up_addr_val = sw_standby ? 8'h00 : upper_address_byte;   // RQ9

  // Upper port next drive
  pin_drive_t up_pin_d;
  always_comb begin
    up_pin_d.o  = (up_addr_sel & up_addr_val) | (~up_addr_sel & up_data_q); // RQ1 RQ3 RQ4 RQ9
    up_pin_d.oe = up_dir_q;                                                 // RQ3 RQ4
    up_pin_d.pu = m1 ? 8'h00 : (up_data_q & ~up_dir_q);                     // RQ5 RQ6
    if (hw_standby) begin
      // Everything floats, pull-ups off
      up_pin_d = '0;                                                        // RQ8
    end
  end

  // Data port next drive
  pin_drive_t db_pin_d;
  always_comb begin
    if (hw_standby) begin
      db_pin_d = '0;                                                        // RQ16
    end else if (expanded) begin
      // Data bus; port registers have no say. Floats in software standby
      db_pin_d.o  = ext_data_out;                                           // RQ10
      db_pin_d.oe = (ext_data_oe && !sw_standby) ? 8'hff : 8'h00;           // RQ10 RQ17
      db_pin_d.pu = 8'h00;                                                  // RQ13
    end else if (hs_req.active) begin
      // Handshake logic owns the pins
      db_pin_d.o  = hs_req.data;                                            // RQ11
      db_pin_d.oe = hs_req.oe ? 8'hff : 8'h00;                              // RQ11
      db_pin_d.pu = hs_req.oe ? 8'h00 : (db_data_q & ~db_dir_q);            // RQ13
    end else begin
      // General-purpose port; state kept through software standby
      db_pin_d.o  = db_data_q;                                              // RQ11 RQ17
      db_pin_d.oe = db_dir_q;                                               // RQ12
      db_pin_d.pu = db_data_q & ~db_dir_q;                                  // RQ13
    end
  end

  // Upper port registers; mode 1 forces direction to all ones
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_dir_q  <= `UP_DIR_RST;                                             // RQ7
      up_data_q <= `UP_DATA_RST;                                            // RQ7
    end else begin
      if (m1) begin
        up_dir_q <= `MODE1_DIR_VAL;                                         // RQ2 RQ7
      end else if (wr_en && hit_up_dir) begin
        up_dir_q <= pwdata[7:0];
      end
      if (wr_en && hit_up_data) begin
        up_data_q <= pwdata[7:0];                                           // RQ5
      end
    end
  end

  // Data port registers; hardware standby clears them and the latch enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      db_dir_q   <= `DB_DIR_RST;                                            // RQ16
      db_data_q  <= `DB_DATA_RST;                                           // RQ16
      latch_en_q <= 1'b0;                                                   // RQ16
    end else if (hw_standby) begin
      db_dir_q   <= `DB_DIR_RST;                                            // RQ16
      db_data_q  <= `DB_DATA_RST;                                           // RQ16
      latch_en_q <= 1'b0;                                                   // RQ16
    end else begin
      if (wr_en && hit_db_dir) begin
        db_dir_q <= pwdata[7:0];
      end
      if (wr_en && hit_db_data) begin
        db_data_q <= pwdata[7:0];
      end
      if (wr_en && hit_hs) begin
        latch_en_q <= pwdata[`LATCH_EN_BIT];
      end
    end
  end

  // Strobe latch; strobe taken as synchronous, so edges are sampled levels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strobe_prev_q  <= 1'b1;
      strobe_latch_q <= 8'h00;
    end else begin
      strobe_prev_q <= input_strobe_n;
      if (capture) begin
        strobe_latch_q <= db_pin_i;                                         // RQ14
      end
    end
  end

  // APB answer: one wait-free access, data fixed at the setup edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= setup_ph;
      pslverr_q <= setup_ph && !hit_any;
      if (setup_ph && !pwrite) begin
        prdata_q <= {24'h00_0000, rd_byte};
      end
    end
  end

  // Registered pin drive and data bus return path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_pin_q      <= '0;
      db_pin_q      <= '0;
      ext_data_in_q <= 8'h00;
    end else begin
      up_pin_q      <= up_pin_d;
      db_pin_q      <= db_pin_d;
      ext_data_in_q <= db_pin_i;                                            // RQ10
    end
  end

  assign prdata              = prdata_q;
  assign pready              = pready_q;
  assign pslverr             = pslverr_q;
  assign up_pin              = up_pin_q;
  assign db_pin              = db_pin_q;
  assign ext_data_in         = ext_data_in_q;
  assign strobe_latch_enable = latch_en_q;

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_setup;
    psel && !penable;
  endsequence

  sequence s_access_done;
    pready_q && psel && penable;
  endsequence

  property p_apb_answer;
    s_setup |=> pready_q ##1 !pready_q;
  endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("APB answer timing wrong");

  property p_mode1_dir_ones;
    m1 ##1 m1 |=> up_dir_q == 8'hff;
  endproperty
  a_mode1_dir_ones: assert property (p_mode1_dir_ones) else $error("Mode 1 direction not ones"); // RQ2

  property p_mode1_addr;
    m1 && !hw_standby && !sw_standby && up_dir_q == 8'hff |=>
      up_pin_q.oe == 8'hff && up_pin_q.o == $past(upper_address_byte);
  endproperty
  a_mode1_addr: assert property (p_mode1_addr) else $error("Mode 1 address not driven"); // RQ1

  property p_pu_off_outputs;
    1'b1 |=> (up_pin_q.pu & $past(up_dir_q)) == 8'h00 && (db_pin_q.pu & db_pin_q.oe) == 8'h00;
  endproperty
  a_pu_off_outputs: assert property (p_pu_off_outputs) else $error("Pull-up on an output"); // RQ6

  property p_hw_float;
    hw_standby |=> up_pin_q == '0 && db_pin_q == '0;
  endproperty
  a_hw_float: assert property (p_hw_float) else $error("Pins driven in hardware standby"); // RQ8

  property p_hw_clear;
    hw_standby |=> db_dir_q == 8'h00 && db_data_q == 8'h00 && !latch_en_q;
  endproperty
  a_hw_clear: assert property (p_hw_clear) else $error("Data port not cleared"); // RQ16

  property p_dir_read;
    s_setup and (hit_up_dir || hit_db_dir) && !pwrite |=> prdata_q == 32'h0000_00ff;
  endproperty
  a_dir_read: assert property (p_dir_read) else $error("Direction read not ones"); // RQ19

  property p_strobe_capture;
    m3 && latch_en_q && strobe_prev_q && !input_strobe_n |=> strobe_latch_q == $past(db_pin_i);
  endproperty
  a_strobe_capture: assert property (p_strobe_capture) else $error("Strobe data lost"); // RQ14

  property p_exp_bus_float;
    expanded && !hw_standby && (!ext_data_oe || sw_standby) |=> db_pin_q.oe == 8'h00;
  endproperty
  a_exp_bus_float: assert property (p_exp_bus_float) else $error("Data bus driven"); // RQ10

  property p_sw_addr_low;
    m1 && sw_standby && !hw_standby && up_dir_q == 8'hff |=> up_pin_q.o == 8'h00;
  endproperty
  a_sw_addr_low: assert property (p_sw_addr_low) else $error("Address not low"); // RQ9

  property p_write_lands;
    s_access_done and pwrite && hit_db_data && !hw_standby |=> db_data_q == $past(pwdata[7:0]);
  endproperty
  a_write_lands: assert property (p_write_lands) else $error("Data port write lost");

  // Mode 2: direction picks address output or input per pin
  property p_mode2_per_pin;
    m2 && !hw_standby && !sw_standby |=> up_pin_q.oe == $past(up_dir_q) &&
      ((up_pin_q.o ^ $past(upper_address_byte)) & $past(up_dir_q)) == 8'h00;
  endproperty
  a_mode2_per_pin: assert property (p_mode2_per_pin) else $error("Mode 2 pin use wrong"); // RQ3

  // Mode 3: upper port is a plain latch-driven port
  property p_mode3_upper_io;
    m3 && !hw_standby |=> up_pin_q.o == $past(up_data_q) && up_pin_q.oe == $past(up_dir_q);
  endproperty
  a_mode3_upper_io: assert property (p_mode3_upper_io) else $error("Mode 3 upper port wrong"); // RQ4

  // Data bit sets the pull-up of an input pin
  property p_upper_pullup;
    !m1 && !hw_standby |=> up_pin_q.pu == ($past(up_data_q) & ~$past(up_dir_q));
  endproperty
  a_upper_pullup: assert property (p_upper_pullup) else $error("Upper pull-up wrong"); // RQ5

  // No pull-ups at all in mode 1, while the whole port carries the address
  property p_mode1_no_pullup;
    m1 |=> up_pin_q.pu == 8'h00;
  endproperty
  a_mode1_no_pullup: assert property (p_mode1_no_pullup) else $error("Mode 1 pull-up on"); // RQ6

  // Software standby keeps general outputs on the latch value
  property p_sw_gpio_kept;
    m3 && sw_standby && !hw_standby |=> up_pin_q.o == $past(up_data_q);
  endproperty
  a_sw_gpio_kept: assert property (p_sw_gpio_kept) else $error("Standby output lost"); // RQ9

  // Expanded modes: bus write data reaches the pins
  property p_bus_drive;
    expanded && !hw_standby && !sw_standby && ext_data_oe |=>
      db_pin_q.oe == 8'hff && db_pin_q.o == $past(ext_data_out);
  endproperty
  a_bus_drive: assert property (p_bus_drive) else $error("Data bus not driven"); // RQ10

  // Handshake logic owns the data port when active in mode 3
  property p_hs_owns;
    m3 && !hw_standby && hs_req.active |=>
      db_pin_q.o == $past(hs_req.data) && db_pin_q.oe == {8{$past(hs_req.oe)}};
  endproperty
  a_hs_owns: assert property (p_hs_owns) else $error("Handshake drive wrong"); // RQ11

  // General-purpose data port follows its direction bits
  property p_db_gpio;
    m3 && !hw_standby && !hs_req.active |=>
      db_pin_q.oe == $past(db_dir_q) && db_pin_q.o == $past(db_data_q);
  endproperty
  a_db_gpio: assert property (p_db_gpio) else $error("Data port drive wrong"); // RQ12 RQ17

  // Data port pull-ups stay off in the expanded modes
  property p_db_no_pullup;
    expanded |=> db_pin_q.pu == 8'h00;
  endproperty
  a_db_no_pullup: assert property (p_db_no_pullup) else $error("Data port pull-up on"); // RQ13

  // Held strobe value only changes on a qualified falling edge
  property p_latch_holds;
    !capture |=> $stable(strobe_latch_q);
  endproperty
  a_latch_holds: assert property (p_latch_holds) else $error("Strobe latch moved"); // RQ14

  // Latch disabled: input pins read live
  property p_db_live_read;
    s_setup and !pwrite && hit_db_data && !latch_en_q |=> prdata_q[7:0] ==
      (($past(db_dir_q) & $past(db_data_q)) | (~$past(db_dir_q) & $past(db_pin_i)));
  endproperty
  a_db_live_read: assert property (p_db_live_read) else $error("Live read wrong"); // RQ15 RQ18

  // Upper port read: latch for outputs, pin for inputs
  property p_up_read;
    s_setup and !pwrite && hit_up_data |=> prdata_q[7:0] ==
      (($past(up_dir_q) & $past(up_data_q)) | (~$past(up_dir_q) & $past(up_pin_i)));
  endproperty
  a_up_read: assert property (p_up_read) else $error("Upper read wrong"); // RQ18

  // Unmapped address answers with an error
  property p_unmapped_err;
    s_setup and !hit_any |=> pslverr_q && pready_q;
  endproperty
  a_unmapped_err: assert property (p_unmapped_err) else $error("No error on unmapped address");

  // Upper data write lands in the latch
  property p_upper_write;
    s_access_done and pwrite && hit_up_data |=> up_data_q == $past(pwdata[7:0]);
  endproperty
  a_upper_write: assert property (p_upper_write) else $error("Upper data write lost"); // RQ5

endmodule
`default_nettype wire

// ===== testbench/pin_model.sv
`timescale 1ns/1ps
`default_nettype none
// Far side of one 8-bit pin group
module pin_model
  import adport_pkg::*;
(
  input  wire pin_drive_t drv,
  input  wire logic [7:0] ext_val,
  output logic      [7:0] pin_i
);
  // Device drive wins over the external source on each line
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_i[i] = drv.oe[i] ? drv.o[i] : ext_val[i];
    end
  end
endmodule
`default_nettype wire

// ===== testbench/tb_address_data_port_pair.sv
`timescale 1ns/1ps
`default_nettype none
`include "adport_defines.svh"
module tb_address_data_port_pair
  import adport_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata, r;
  mode_t       op_mode;
  logic        hw_standby, sw_standby, ext_data_oe, input_strobe_n, e, strobe_latch_enable;
  logic [7:0]  upper_address_byte, ext_data_out, ext_data_in, up_pin_i, db_pin_i;
  logic [7:0]  up_ext, db_ext, dir, dat, a;
  hs_req_t     hs_req;
  pin_drive_t  up_pin, db_pin;
  int          bad_count, check_count;

  address_data_port_pair address_data_port_pair_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .op_mode(op_mode),
    .hw_standby(hw_standby), .sw_standby(sw_standby),
    .upper_address_byte(upper_address_byte), .ext_data_out(ext_data_out),
    .ext_data_oe(ext_data_oe), .ext_data_in(ext_data_in), .hs_req(hs_req),
    .input_strobe_n(input_strobe_n), .up_pin_i(up_pin_i), .up_pin(up_pin),
    .db_pin_i(db_pin_i), .db_pin(db_pin), .strobe_latch_enable(strobe_latch_enable));
  pin_model up_model_inst (.drv(up_pin), .ext_val(up_ext), .pin_i(up_pin_i));
  pin_model db_model_inst (.drv(db_pin), .ext_val(db_ext), .pin_i(db_pin_i));

  // Free-running bus clock, 50 ns period
  always #25 pclk = ~pclk;

  // Verdict and end of run
  task automatic end_of_test();
    if (bad_count == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    check_count++;
    if (g !== x) begin
      $display("MISMATCH %s exp %h got %h", n, x, g);
      bad_count++;
    end
  endtask

  // One APB transfer; waits on pready under a bound
  task automatic apb(input logic w, input logic [31:0] ad, input logic [7:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      chk("pready", 32'h1, {31'h0, pready});
      end_of_test();
    end
  endtask

  // Let registered pin drive land before looking
  task automatic settle();
    repeat (3) @(posedge pclk);
  endtask

  task automatic rst(input mode_t m);
    presetn <= 1'b0;
    op_mode <= m;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    settle();
  endtask

  // Live pins for inputs, latch for outputs
  function automatic logic [31:0] rd_exp(input logic [7:0] d, x, v);
    return {24'h000000, (x & d) | (v & ~d)};
  endfunction

  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    op_mode = MODE_SINGLE; hw_standby = 0; sw_standby = 0; upper_address_byte = 0;
    ext_data_out = 0; ext_data_oe = 0; hs_req = '0; input_strobe_n = 1;
    up_ext = 8'h00; db_ext = 8'h00; bad_count = 0; check_count = 0;
    void'($urandom(9626));
    rst(MODE_SINGLE);
    chk("up_oe", 0, up_pin.oe);
    chk("up_pu", 0, up_pin.pu);
    chk("db_oe", 0, db_pin.oe);
    apb(0, `UP_DIR_ADDR, 0);
    chk("up_dir_rd", 32'hff, r);
    apb(0, `DB_DIR_ADDR, 0);
    chk("db_dir_rd", 32'hff, r);
    // Mode 3 plain I/O, corners then random
    for (int k = 0; k < 6; k++) begin
      dir = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($urandom);
      dat = 8'($urandom);
      up_ext <= 8'($urandom);
      db_ext <= 8'($urandom);
      apb(1, `UP_DIR_ADDR, dir);
      apb(1, `UP_DATA_ADDR, dat);
      apb(1, `DB_DIR_ADDR, dir);
      apb(1, `DB_DATA_ADDR, dat);
      settle();
      chk("up_oe", dir, up_pin.oe);
      chk("up_o", dat & dir, up_pin.o & dir);
      chk("up_pu", dat & ~dir, up_pin.pu);
      chk("db_oe", dir, db_pin.oe);
      chk("db_pu", dat & ~dir, db_pin.pu);
      apb(0, `UP_DATA_ADDR, 0);
      chk("up_rd", rd_exp(dir, dat, up_ext), r);
      apb(0, `DB_DATA_ADDR, 0);
      chk("db_rd", rd_exp(dir, dat, db_ext), r);
    end
    apb(0, 32'h00000100, 0);
    chk("unmapped_err", 1, e);
    chk("unmapped_rd", 0, r);
    // Strobe latch holds the level seen at the falling edge
    apb(1, `DB_DIR_ADDR, 8'h00);
    apb(1, `HS_CTRL_ADDR, 8'h01);
    a = 8'($urandom);
    db_ext <= a;
    settle();
    chk("latch_en", 1, strobe_latch_enable);
    input_strobe_n <= 1'b0;
    repeat (2) @(posedge pclk);
    db_ext <= ~a;
    input_strobe_n <= 1'b1;
    apb(0, `DB_DATA_ADDR, 0);
    chk("latched", a, r);
    apb(1, `HS_CTRL_ADDR, 8'h00);
    apb(0, `DB_DATA_ADDR, 0);
    chk("transparent", ~a & 8'hff, r);
    hs_req <= '{active: 1'b1, oe: 1'b1, data: 8'hc3};
    settle();
    chk("hs_oe", 8'hff, db_pin.oe);
    chk("hs_o", 8'hc3, db_pin.o);
    hs_req <= '0;
    // Software standby keeps drive, hardware standby floats
    apb(1, `DB_DIR_ADDR, 8'hff);
    apb(1, `DB_DATA_ADDR, 8'h5a);
    sw_standby <= 1'b1;
    settle();
    chk("sw_db_oe", 8'hff, db_pin.oe);
    chk("sw_db_o", 8'h5a, db_pin.o);
    sw_standby <= 1'b0;
    hw_standby <= 1'b1;
    settle();
    chk("hw_up_oe", 0, up_pin.oe);
    chk("hw_up_pu", 0, up_pin.pu);
    chk("hw_db_oe", 0, db_pin.oe);
    hw_standby <= 1'b0;
    settle();
    chk("hw_db_clr", 0, db_pin.oe | db_pin.pu);
    // Mode 2: per-pin address output
    rst(MODE_EXP_ROM);
    dir = 8'($urandom);
    upper_address_byte <= 8'($urandom);
    apb(1, `UP_DIR_ADDR, dir);
    apb(1, `UP_DATA_ADDR, 8'hff);
    apb(1, `DB_DATA_ADDR, 8'hff);
    settle();
    chk("m2_oe", dir, up_pin.oe);
    chk("m2_o", upper_address_byte & dir, up_pin.o & dir);
    chk("m2_pu", ~dir & 8'hff, up_pin.pu);
    chk("m2_db_pu", 0, db_pin.pu);
    sw_standby <= 1'b1;
    settle();
    chk("m2_sw_addr", 0, up_pin.o & dir);
    sw_standby <= 1'b0;
    // Mode 1: full address byte and data bus
    rst(MODE_EXP_NOROM);
    chk("m1_oe", 8'hff, up_pin.oe);
    upper_address_byte <= 8'($urandom);
    ext_data_out <= 8'($urandom);
    ext_data_oe <= 1'b1;
    apb(1, `UP_DIR_ADDR, 8'h00);
    apb(1, `UP_DATA_ADDR, 8'hff);
    apb(1, `DB_DIR_ADDR, 8'h00);
    settle();
    chk("m1_dir", 8'hff, up_pin.oe);
    chk("m1_o", upper_address_byte, up_pin.o);
    chk("m1_pu", 0, up_pin.pu);
    chk("m1_db_oe", 8'hff, db_pin.oe);
    chk("m1_db_o", ext_data_out, db_pin.o);
    ext_data_oe <= 1'b0;
    db_ext <= 8'($urandom);
    apb(1, `DB_DIR_ADDR, 8'hff);
    settle();
    chk("m1_db_in", db_ext, ext_data_in);
    chk("m1_db_off", 0, db_pin.oe);
    ext_data_oe <= 1'b1;
    sw_standby <= 1'b1;
    settle();
    chk("m1_sw_db", 0, db_pin.oe);
    end_of_test();
  end
endmodule
`default_nettype wire
